// >>> logic/lpc_pkg.sv
// package for the low-power clock and thermal trip controller
package lpc_pkg;

   // ---------------------------------------------------------------
   // timing and widths
   // ---------------------------------------------------------------
   localparam int            SG_ENTRY_CLOCKS = 20;     // bus clocks from ack response to stop-grant
   localparam int            CNT_W           = 5;
   localparam logic [CNT_W-1:0] SG_CNT_LAST  = CNT_W'(SG_ENTRY_CLOCKS - 1);
   localparam logic [CNT_W-1:0] CNT_ZERO     = 5'h00;
   localparam logic [CNT_W-1:0] CNT_ONE      = 5'h01;

   // ---------------------------------------------------------------
   // power state machine
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      LPC_NORMAL   = 3'b000,   // executing
      LPC_HALT     = 3'b001,   // halt powerdown
      LPC_SG_ACK   = 3'b010,   // stop-grant ack issued, waiting for response
      LPC_SG_WAIT  = 3'b011,   // counting toward stop-grant
      LPC_STOPGNT  = 3'b100,   // stop-grant
      LPC_SLEEP    = 3'b101,   // sleep, only pll runs
      LPC_SMM      = 3'b110,   // system management state
      LPC_SHUTDOWN = 3'b111    // thermal shutdown
   } lpc_state_t;

endpackage

// >>> logic/lpc_ctrl.sv
// low-power clock gating and thermal trip controller
//
// Operation
// - stop-grant plus sleep request enters sleep, pll only
// - sleep blocks snoops and interrupts
// - sleep reacts only to reset, thermal trip or sleep release
// - sleep release returns to stop-grant, clocks restart
// - stop-clock issues ack, gates core clocks
// - stop-grant keeps bus and interrupt clocks
// - stop-clock release restarts clocks, resumes execution
// - bus clock untouched; stop-clock is asynchronous
// - management interrupt saves state, acks, runs handler
// - management interrupt at reset release tri-states outputs
// - thermal trip asserts flag, stops clocks, halts
// - trip flag latched until system reset
// - reset releases trip flag even when hot
// - after reset boot; persistent trip re-shuts down
// - stop-grant entered 20 clocks after ack response
// - sleep request accepted only in stop-grant
`timescale 1ns/1ps
module lpc_ctrl
   import lpc_pkg::*;
(
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic rst_n,
   // asynchronous requests from the platform
   input  wire logic stop_clock_request_n,
   input  wire logic sleep_request_n,
   input  wire logic sys_mgmt_interrupt_n,
   // on-die events
   input  wire logic thermalTrip,      // sensor over temperature level
   input  wire logic haltInstr,        // core executed halt, pulse
   input  wire logic wakeEvent,        // interrupt or init wakes from halt
   input  wire logic smmReturn,        // management handler finished, pulse
   input  wire logic snoopReq,         // snoop seen on the bus
   input  wire logic intReq,           // interrupt request
   input  wire logic ackResponse,      // response phase of our special cycle
   // special bus cycles
   output logic      stopGrantAckReq,  // request stop-grant acknowledge cycle
   output logic      smiAckReq,        // request smi acknowledge cycle
   output logic      smmSaveState,     // pulse: save context
   output logic      bootStart,        // pulse: start at boot vector
   // clock gates
   output logic      coreClkEn,
   output logic      busClkEn,
   output logic      apicClkEn,
   output logic      pllEn,
   output logic      execEn,
   // snoop and interrupt acceptance
   output logic      snoopEn,
   output logic      intEn,
   // status
   output logic      inSmm,            // system_management_state
   output logic      outputsTristate,
   output logic      thermal_shutdown_flag_n
);

   // ---------------------------------------------------------------
   // synchronisers
   // ---------------------------------------------------------------
   logic [2:0] syncA_q;   // first stage, read only by second stage
   logic [2:0] syncB_q;   // second stage, active-high requests
   logic [2:0] rawReq;

   // invert at the pin so stages hold active-high requests
   assign rawReq = {~sys_mgmt_interrupt_n, ~sleep_request_n, ~stop_clock_request_n};

   // two flops per request; they run through reset, so the strap level on
   // the interrupt pin has reached the second stage by the release edge;
   // stop-clock never reaches the bus clock path
   always_ff @(posedge sys_clk) begin
      syncA_q <= rawReq;
      syncB_q <= syncA_q;
   end

   logic stopReq;
   logic sleepReq;
   logic smiReq;
   assign stopReq  = syncB_q[0];
   assign sleepReq = syncB_q[1];
   assign smiReq   = syncB_q[2];

   // ---------------------------------------------------------------
   // reset release capture
   // ---------------------------------------------------------------
   logic inReset_q;     // one while reset held, clears after release
   logic triState_q;    // tri-state option caught at release
   logic bootPulse_q;

   // sample smi request on the first edge after release; raw pin is
   // synchronised, so the strap is the synchronised level at release
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         inReset_q   <= 1'b1;
         triState_q  <= 1'b0;
         bootPulse_q <= 1'b0;
      end else begin
         inReset_q   <= 1'b0;
         bootPulse_q <= inReset_q;
         if (inReset_q) begin
            triState_q <= smiReq;
         end
      end
   end

   // ---------------------------------------------------------------
   // thermal trip latch
   // ---------------------------------------------------------------
   logic tripSync1_q;
   logic tripSync2_q;
   logic tripLatch_q;

   // trip level is analog-derived, so synchronise it too; the latch is
   // cleared only by reset, even with the die still hot
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         tripSync1_q <= 1'b0;
         tripSync2_q <= 1'b0;
         tripLatch_q <= 1'b0;
      end else begin
         tripSync1_q <= thermalTrip;
         tripSync2_q <= tripSync1_q;
         if (tripSync2_q) begin
            tripLatch_q <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // power state machine
   // ---------------------------------------------------------------
   lpc_state_t          state_q;
   lpc_state_t          state_d;
   lpc_state_t          resume_q;   // state to return to after smm
   lpc_state_t          resume_d;
   logic [CNT_W-1:0]    cnt_q;
   logic [CNT_W-1:0]    cnt_d;
   logic                smiPend_q;  // smi latched during stop-grant
   logic                smiPend_d;
   logic                smiPrev_q;
   logic                smiRise;

   assign smiRise = smiReq & ~smiPrev_q;

   // next-state logic; shutdown wins over everything but reset
   always_comb begin
      state_d   = state_q;
      resume_d  = resume_q;
      cnt_d     = cnt_q;
      smiPend_d = smiPend_q;
      unique case (state_q)
         LPC_NORMAL, LPC_HALT: begin
            // sleep request ignored here
            if (stopReq) begin
               state_d = LPC_SG_ACK;
            end else if (smiRise || smiPend_q) begin
               smiPend_d = 1'b0;
               resume_d  = state_q;
               state_d   = LPC_SMM;
            end else if (state_q == LPC_NORMAL && haltInstr) begin
               state_d = LPC_HALT;
            end else if (state_q == LPC_HALT && wakeEvent) begin
               state_d = LPC_NORMAL;
            end
         end
         LPC_SG_ACK: begin
            cnt_d = CNT_ZERO;
            if (ackResponse) begin
               state_d = LPC_SG_WAIT;
            end
         end
         LPC_SG_WAIT: begin
            // fixed count after the response phase
            if (cnt_q == SG_CNT_LAST) begin
               state_d = LPC_STOPGNT;
            end else begin
               cnt_d = cnt_q + CNT_ONE;
            end
         end
         LPC_STOPGNT: begin
            if (smiRise) begin
               smiPend_d = 1'b1;     // serviced once back in normal or halt
            end
            if (sleepReq) begin
               state_d = LPC_SLEEP;
            end else if (!stopReq) begin
               state_d = resume_q;
            end
         end
         LPC_SLEEP: begin
            // every input but sleep release and the thermal trip is ignored
            if (!sleepReq) begin
               state_d = LPC_STOPGNT;
            end
         end
         LPC_SMM: begin
            if (smmReturn) begin
               state_d = resume_q;
            end
         end
         LPC_SHUTDOWN: begin
            state_d = LPC_SHUTDOWN;
         end
      endcase
      // normal and halt return point for stop-grant exit
      if ((state_q == LPC_NORMAL || state_q == LPC_HALT) && stopReq) begin
         resume_d = state_q;
      end
      if (tripLatch_q) begin
         state_d = LPC_SHUTDOWN;
      end
   end

   // state registers; reset restarts execution in normal
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state_q   <= LPC_NORMAL;
         resume_q  <= LPC_NORMAL;
         cnt_q     <= CNT_ZERO;
         smiPend_q <= 1'b0;
         // follow the pin during reset: a strap held across release
         // must not look like a fresh interrupt edge
         smiPrev_q <= smiReq;
      end else begin
         state_q   <= state_d;
         resume_q  <= resume_d;
         cnt_q     <= cnt_d;
         smiPend_q <= smiPend_d;
         smiPrev_q <= smiReq;
      end
   end

   // one-cycle marker of smm entry for save and acknowledge
   logic smiPrevEntry;
   logic inSmmPrev_q;
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         inSmmPrev_q <= 1'b0;
      end else begin
         inSmmPrev_q <= (state_q == LPC_SMM);
      end
   end
   assign smiPrevEntry = ~inSmmPrev_q;

   // ---------------------------------------------------------------
   // decoded outputs
   // ---------------------------------------------------------------
   logic gated;    // core clocks gated
   logic asleep;
   logic down;
   assign gated  = (state_q == LPC_STOPGNT) | (state_q == LPC_SLEEP) | (state_q == LPC_HALT);
   assign asleep = (state_q == LPC_SLEEP);
   // the latch stops clocks at once, one cycle before the state follows
   assign down   = (state_q == LPC_SHUTDOWN) | tripLatch_q;

   assign coreClkEn = ~gated & ~down;
   assign busClkEn  = ~asleep & ~down;
   assign apicClkEn = ~asleep & ~down;
   assign pllEn     = 1'b1;
   assign execEn    = ~gated & ~down & ~inReset_q;
   assign snoopEn   = ~asleep & ~down;
   assign intEn     = ~asleep & ~down;

   assign stopGrantAckReq = (state_q == LPC_SG_ACK);
   // ack goes out on entry even if the handler returns at once
   assign smiAckReq       = smmSaveState;
   assign smmSaveState    = (state_q == LPC_SMM) && (resume_q != LPC_SMM) && smiPrevEntry;
   assign inSmm           = (state_q == LPC_SMM);
   assign bootStart       = bootPulse_q;
   assign outputsTristate = triState_q;
   // driven low while latched; platform cuts power on it
   assign thermal_shutdown_flag_n = ~tripLatch_q;

endmodule

// >>> sim/lpc_ctrl_sva.sv
// port assertions for the low-power clock and trip controller
`timescale 1ns/1ps
module lpc_ctrl_sva (
   // all watched ports of lpc_ctrl
   input wire logic sys_clk, rst_n, stop_clock_request_n, sleep_request_n,
   input wire logic sys_mgmt_interrupt_n, thermalTrip, ackResponse, stopGrantAckReq,
   input wire logic smiAckReq, smmSaveState, bootStart, coreClkEn, busClkEn,
   input wire logic pllEn, execEn, snoopEn, intEn, inSmm, outputsTristate,
   input wire logic thermal_shutdown_flag_n
);
   // ------
   // states read back from the gates; the trip flag keeps shutdown out
   // ------
   wire sgSt  = !coreClkEn && busClkEn && thermal_shutdown_flag_n;
   wire slpSt = !busClkEn && pllEn && thermal_shutdown_flag_n;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   property p_ack; $fell(stop_clock_request_n) && coreClkEn && !inSmm |-> ##3 stopGrantAckReq;
   endproperty
   a_ack: assert property (p_ack) else $error("ack cycle late");
   property p_sg; ackResponse && stopGrantAckReq |-> ##20 coreClkEn ##1 !coreClkEn; endproperty
   a_sg: assert property (p_sg) else $error("stop-grant entry time");
   property p_slp; $fell(sleep_request_n) && sgSt |-> ##3 slpSt && !snoopEn && !intEn;
   endproperty
   a_slp: assert property (p_slp) else $error("sleep entry");
   property p_hold; slpSt && !sleep_request_n && !$past(sleep_request_n)
      |=> slpSt || !thermal_shutdown_flag_n; endproperty
   a_hold: assert property (p_hold) else $error("sleep left early");
   property p_wake; $rose(stop_clock_request_n) && sgSt |-> ##3 coreClkEn && execEn; endproperty
   a_wake: assert property (p_wake) else $error("no restart");
   property p_mgmt; $rose(inSmm) |-> smiAckReq && smmSaveState ##1 !smiAckReq; endproperty
   a_mgmt: assert property (p_mgmt) else $error("handler entry");
   property p_trip; $rose(thermalTrip) && thermal_shutdown_flag_n
      |-> ##3 !thermal_shutdown_flag_n && !execEn; endproperty
   a_trip: assert property (p_trip) else $error("trip late");
   property p_latch; !thermal_shutdown_flag_n |=> !thermal_shutdown_flag_n && !coreClkEn;
   endproperty
   a_latch: assert property (p_latch) else $error("trip not held");
   property p_boot; $rose(rst_n) |-> thermal_shutdown_flag_n ##1 bootStart; endproperty
   a_boot: assert property (p_boot) else $error("boot start");
   property p_strap; $rose(rst_n) |=> outputsTristate == !$past(sys_mgmt_interrupt_n, 3);
   endproperty
   a_strap: assert property (p_strap) else $error("strap capture");
endmodule
bind lpc_ctrl lpc_ctrl_sva u_lpc_ctrl_sva (.*);

// >>> sim/lpc_platform_model.sv
// platform model: answers the stop-grant ack cycle and cuts power on a trip
`timescale 1ns/1ps
module lpc_platform_model (
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   // response delay in bus clocks, zero answers at once
   input  wire logic [3:0] ackDelay,
   // device outputs
   input  wire logic       stopGrantAckReq,
   input  wire logic       thermal_shutdown_flag_n,
   // platform answers
   output logic            ackResponse,
   output logic            powerOn
);
   logic [3:0] waitQ;   // cycles the ack cycle has waited
   // one-cycle response phase after ackDelay clocks
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         ackResponse <= 1'b0;
         waitQ       <= 4'h0;
      end else begin
         ackResponse <= 1'b0;
         if (!stopGrantAckReq || ackResponse) begin
            waitQ <= 4'h0;
         end else if (waitQ == ackDelay) begin
            ackResponse <= 1'b1;
         end else begin
            waitQ <= waitQ + 4'h1;
         end
      end
   end
   // power drops on the trip flag; only reset brings it back
   always @(posedge sys_clk) begin
      if (!rst_n) powerOn <= 1'b1;
      else if (!thermal_shutdown_flag_n) powerOn <= 1'b0;
   end
endmodule

// >>> sim/lpc_ctrl_test.sv
// self-checking bench for the low-power clock and trip controller
`timescale 1ns/1ps
module lpc_ctrl_test;
   // ------
   // stimulus and observed signals
   // ------
   logic sys_clk = 1'b0, rst_n = 1'b0, stop_clock_request_n = 1'b1, sleep_request_n = 1'b1;
   logic sys_mgmt_interrupt_n = 1'b1, thermalTrip = 1'b0, smmReturn = 1'b0;
   logic [3:0] ackDelay = 4'h0;
   logic ackResponse, powerOn, stopGrantAckReq, smiAckReq, smmSaveState, bootStart, inSmm;
   logic coreClkEn, busClkEn, apicClkEn, pllEn, execEn, snoopEn, intEn;
   logic outputsTristate, thermal_shutdown_flag_n;
   int n_errors = 0, compares = 0, cycles = 0;
   always #12.5 sys_clk = ~sys_clk;
   // halt, wake, snoop and interrupt inputs do not steer the power states here
   lpc_ctrl u_lpc_ctrl (.haltInstr(1'b0), .wakeEvent(1'b0), .snoopReq(1'b0), .intReq(1'b0), .*);
   lpc_platform_model u_lpc_platform_model (.*);
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #2;
   endtask
   task automatic check(input logic seen, input logic exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: saw %b want %b", $time, seen, exp);
      end
   endtask
   task automatic conclude;
      if (n_errors == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // a hang counts as a mismatch
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         conclude;
      end
   end
   // reset with a strap level on the interrupt pin, held steady across release
   task automatic pulse_reset(input int n, input logic strap);
      rst_n = 1'b0;
      sys_mgmt_interrupt_n = strap;
      tick(n);
      check(thermal_shutdown_flag_n, 1'b1);
      rst_n = 1'b1;
      tick(1);
      check(outputsTristate, !strap);
      check(bootStart, 1'b1);
      tick(1);
      check(bootStart, 1'b0);
   endtask
   // stop request held until stop-grant is reached
   task automatic enter_sg(input logic [3:0] dly);
      int i;
      ackDelay = dly;
      stop_clock_request_n = 1'b0;
      tick(2);
      check(stopGrantAckReq, 1'b0);
      tick(1);
      check(stopGrantAckReq, 1'b1);
      for (i = 0; i < 30 && ackResponse !== 1'b1; i++) tick(1);
      tick(20);
      check(coreClkEn, 1'b1);
      tick(1);
      check(coreClkEn, 1'b0);
      check(busClkEn & apicClkEn & snoopEn & intEn, 1'b1);
   endtask
   // sleep refused in normal, then entered from stop-grant with a slow answer
   task automatic t_sleep;
      sleep_request_n = 1'b0;
      tick(5);
      check(busClkEn, 1'b1);
      sleep_request_n = 1'b1;
      tick(3);
      enter_sg(4'h7);
      sleep_request_n = 1'b0;
      tick(3);
      check(busClkEn | coreClkEn | snoopEn | intEn, 1'b0);
      check(pllEn, 1'b1);
      stop_clock_request_n = 1'b1;
      tick(6);
      check(busClkEn, 1'b0);
      sleep_request_n = 1'b1;
      tick(3);
      check(busClkEn, 1'b1);
      tick(3);
      check(coreClkEn & execEn, 1'b1);
   endtask
   // interrupt held off in stop-grant, taken once running again
   task automatic t_stop_mgmt;
      int i;
      enter_sg(4'h0);
      sys_mgmt_interrupt_n = 1'b0;
      tick(4);
      check(inSmm, 1'b0);
      sys_mgmt_interrupt_n = 1'b1;
      stop_clock_request_n = 1'b1;
      tick(2);
      check(coreClkEn, 1'b0);
      tick(1);
      check(coreClkEn, 1'b1);
      for (i = 0; i < 10 && inSmm !== 1'b1; i++) tick(1);
      check(smiAckReq & smmSaveState & inSmm, 1'b1);
      smmReturn = 1'b1;
      tick(1);
      smmReturn = 1'b0;
      tick(2);
      check(inSmm, 1'b0);
   endtask
   // trip, latch, reset while still hot, then a tri-state strap
   task automatic t_trip;
      thermalTrip = 1'b1;
      tick(2);
      check(thermal_shutdown_flag_n, 1'b1);
      tick(1);
      check(thermal_shutdown_flag_n | execEn | coreClkEn, 1'b0);
      thermalTrip = 1'b0;
      tick(8);
      check(thermal_shutdown_flag_n | powerOn, 1'b0);
      thermalTrip = 1'b1;
      pulse_reset(5, 1'b1);
      tick(4);
      check(thermal_shutdown_flag_n, 1'b0);
      thermalTrip = 1'b0;
      pulse_reset(5, 1'b0);
      sys_mgmt_interrupt_n = 1'b1;
      tick(4);
      check(outputsTristate, 1'b1);
   endtask
   initial begin
      pulse_reset(20, 1'b1);
      t_sleep;
      t_stop_mgmt;
      t_trip;
      conclude;
   end
endmodule
